// ---- include/dtc_pkg.sv ----
// package for the dual timer control fields block: offsets, fields, resets, carriers
//--------------------------------------------------------------------------
//--------------------------------------------------------------------------
package dtc_pkg;
    //----------------------------------------------------------------------
    // register map
    //----------------------------------------------------------------------
    localparam logic [11:0] TIMER_CONTROL_OFFSET = 12'h00c;
    localparam logic [31:0] TIMER_CONTROL_RESET  = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_READ_VALUE  = 32'h0000_0000;
    //----------------------------------------------------------------------
    // field positions
    //----------------------------------------------------------------------
    localparam int FIRST_RUN_BIT      = 0;
    localparam int FIRST_FREEZE_BIT   = 1;
    localparam int FIRST_EDGE_LSB     = 2;
    localparam int CALENDAR_BIT       = 4;
    localparam int FIRST_TRIGGER_BIT  = 5;
    localparam int FIRST_INVERT_BIT   = 6;
    localparam int SECOND_RUN_BIT     = 8;
    localparam int SECOND_FREEZE_BIT  = 9;
    //----------------------------------------------------------------------
    // edge select encodings
    //----------------------------------------------------------------------
    localparam logic [1:0] EDGE_RISING  = 2'h0;
    localparam logic [1:0] EDGE_FALLING = 2'h1;
    localparam logic [1:0] EDGE_RSVD    = 2'h2;
    localparam logic [1:0] EDGE_BOTH    = 2'h3;

    // control fields as stored
    typedef struct packed {
        logic       second_half_debug_freeze;
        logic       second_half_run;
        logic       first_half_pulse_invert;
        logic       first_half_trigger_out_on;
        logic       calendar_count_on;
        logic [1:0] first_half_edge_select;
        logic       first_half_debug_freeze;
        logic       first_half_run;
    } dtc_ctrl_t;

    // per-half enables that reach the counter datapath
    typedef struct packed {
        logic       count_a;
        logic       count_b;
        logic       calendar_tick_en;
        logic       pulse_invert_a;
        logic       trigger_en_a;
        logic       rise_a;
        logic       fall_a;
    } dtc_drive_t;
endpackage : dtc_pkg

// ---- core/dtc_control.sv ----
// dual timer control fields: apb register and the enables it hands to the timer halves
`timescale 1ns/1ps
`default_nettype none
module dtc_control #(
    parameter int ADDR_W = 12
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                cpu_halted,
    input  wire logic                first_half_output_mode,
    output logic                     first_half_count_en,
    output logic                     second_half_count_en,
    output logic                     calendar_tick_en,
    output logic                     first_half_pulse_invert_eff,
    output logic                     first_half_trigger_en,
    output logic                     first_half_capture_rise,
    output logic                     first_half_capture_fall,
    output dtc_pkg::dtc_ctrl_t       ctrl_fields
);
    //----------------------------------------------------------------------
    // elaboration checks
    //----------------------------------------------------------------------
    if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_width
        $error("dtc_control: ADDR_W must be 4..32");
    end

    // every field must sit inside the 32-bit data word
    if (dtc_pkg::SECOND_FREEZE_BIT > 31) begin : g_bad_field
        $error("dtc_control: field position outside the data word");
    end

    //----------------------------------------------------------------------
    // pin synchronisers for the halt status and the output mode
    //----------------------------------------------------------------------
    localparam int PIN_N = 2; // halt status and output mode

    logic [PIN_N-1:0]      pin_raw;
    wire  [PIN_N-1:0]      pin_sync;
    logic                  halt_sync;
    logic                  mode_sync;

    // gather the asynchronous pins so one loop serves them all
    assign pin_raw = {first_half_output_mode, cpu_halted};

    // two flops per pin; only the second stage is read outside the synchroniser
    for (genvar p = 0; p < PIN_N; p++) begin : g_pin_sync
        logic meta_r;
        logic meta_nxt;
        logic sync_r;
        logic sync_nxt;

        // next values of the two stages
        always_comb begin
            meta_nxt = pin_raw[p];
            sync_nxt = meta_r;
        end

        // the two stages, cleared by reset
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                meta_r <= 1'b0;
                sync_r <= 1'b0;
            end else begin
                meta_r <= meta_nxt;
                sync_r <= sync_nxt;
            end
        end

        assign pin_sync[p] = sync_r; // hand the settled level on
    end

    // named taps of the settled pins
    assign halt_sync = pin_sync[0];
    assign mode_sync = pin_sync[1];

    //----------------------------------------------------------------------
    // apb slave and control register
    //----------------------------------------------------------------------
    dtc_pkg::dtc_ctrl_t ctrl_r;
    dtc_pkg::dtc_ctrl_t ctrl_nxt;
    logic [31:0]        prdata_nxt;
    logic               pslverr_nxt;
    logic               pready_nxt;
    logic               hit;
    logic               setup;
    logic               access;
    wire  [31:0]        wmask;
    logic [31:0]        cur_word;
    logic [31:0]        new_word;

    // transfer phases: setup prepares the answer, access commits a write
    assign setup  = psel && !penable;
    assign access = psel && penable && pready;

    // address decode: the control word is the only mapped location
    always_comb begin
        if (paddr == ADDR_W'(dtc_pkg::TIMER_CONTROL_OFFSET)) begin
            hit = 1'b1;
        end else begin
            hit = 1'b0;
        end
    end

    // byte-lane write mask, one lane per strobe bit
    for (genvar b = 0; b < 4; b++) begin : g_lane_mask
        assign wmask[8*b +: 8] = {8{pstrb[b]}};
    end

    // read-back word from the named field positions; reserved bits read zero
    always_comb begin
        cur_word = 32'h0000_0000;
        cur_word[dtc_pkg::SECOND_FREEZE_BIT]   = ctrl_r.second_half_debug_freeze;
        cur_word[dtc_pkg::SECOND_RUN_BIT]      = ctrl_r.second_half_run;
        cur_word[dtc_pkg::FIRST_INVERT_BIT]    = ctrl_r.first_half_pulse_invert;
        cur_word[dtc_pkg::FIRST_TRIGGER_BIT]   = ctrl_r.first_half_trigger_out_on;
        cur_word[dtc_pkg::CALENDAR_BIT]        = ctrl_r.calendar_count_on;
        cur_word[dtc_pkg::FIRST_EDGE_LSB +: 2] = ctrl_r.first_half_edge_select;
        cur_word[dtc_pkg::FIRST_FREEZE_BIT]    = ctrl_r.first_half_debug_freeze;
        cur_word[dtc_pkg::FIRST_RUN_BIT]       = ctrl_r.first_half_run;
    end

    // bus answer, byte-lane merge and field update; no wait states on any access
    always_comb begin
        new_word    = (cur_word & ~wmask) | (pwdata & wmask);
        ctrl_nxt    = ctrl_r;
        prdata_nxt  = prdata;
        pslverr_nxt = 1'b0;
        pready_nxt  = setup; // ready in the first access cycle
        // the answer is prepared while the setup cycle stands
        if (setup && hit) begin
            prdata_nxt = pwrite ? 32'h0000_0000 : cur_word;
        end else if (setup) begin
            prdata_nxt  = dtc_pkg::UNMAPPED_READ_VALUE;
            pslverr_nxt = 1'b1; // unmapped address
        end
        // a write lands only at the edge at which ready is sampled high
        if (access && hit && pwrite) begin
            ctrl_nxt.second_half_debug_freeze  = new_word[dtc_pkg::SECOND_FREEZE_BIT];
            ctrl_nxt.second_half_run           = new_word[dtc_pkg::SECOND_RUN_BIT];
            ctrl_nxt.first_half_pulse_invert   = new_word[dtc_pkg::FIRST_INVERT_BIT];
            ctrl_nxt.first_half_trigger_out_on = new_word[dtc_pkg::FIRST_TRIGGER_BIT];
            ctrl_nxt.calendar_count_on         = new_word[dtc_pkg::CALENDAR_BIT];
            ctrl_nxt.first_half_edge_select    =
                new_word[dtc_pkg::FIRST_EDGE_LSB +: 2];
            ctrl_nxt.first_half_debug_freeze   = new_word[dtc_pkg::FIRST_FREEZE_BIT];
            ctrl_nxt.first_half_run            = new_word[dtc_pkg::FIRST_RUN_BIT];
        end
    end

    // register the control fields and bus answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r  <= dtc_pkg::dtc_ctrl_t'({dtc_pkg::TIMER_CONTROL_RESET[9:8],
                                             dtc_pkg::TIMER_CONTROL_RESET[6:0]});
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            ctrl_r  <= ctrl_nxt;
            prdata  <= prdata_nxt;
            pready  <= pready_nxt;
            pslverr <= pslverr_nxt;
        end
    end

    //----------------------------------------------------------------------
    // enables handed to the counter datapath
    //----------------------------------------------------------------------
    dtc_pkg::dtc_drive_t drive_nxt;
    dtc_pkg::dtc_drive_t drive_r;

    // run gated by freeze during debugger halt; output controls gated by mode
    always_comb begin
        drive_nxt.count_a = ctrl_r.first_half_run
            && !(ctrl_r.first_half_debug_freeze && halt_sync);
        drive_nxt.count_b = ctrl_r.second_half_run
            && !(ctrl_r.second_half_debug_freeze && halt_sync);
        drive_nxt.calendar_tick_en = ctrl_r.calendar_count_on;
        drive_nxt.pulse_invert_a = ctrl_r.first_half_pulse_invert && mode_sync;
        drive_nxt.trigger_en_a = ctrl_r.first_half_trigger_out_on && mode_sync;
        // capture edge decode; the reserved code arms neither edge
        case (ctrl_r.first_half_edge_select)
            dtc_pkg::EDGE_RISING: begin
                drive_nxt.rise_a = 1'b1;
                drive_nxt.fall_a = 1'b0;
            end
            dtc_pkg::EDGE_FALLING: begin
                drive_nxt.rise_a = 1'b0;
                drive_nxt.fall_a = 1'b1;
            end
            dtc_pkg::EDGE_BOTH: begin
                drive_nxt.rise_a = 1'b1;
                drive_nxt.fall_a = 1'b1;
            end
            default: begin
                drive_nxt.rise_a = 1'b0; // reserved code: no capture
                drive_nxt.fall_a = 1'b0;
            end
        endcase
    end

    // register the drive outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_r <= '0;
        end else begin
            drive_r <= drive_nxt;
        end
    end

    // ctrl_fields mirrors the control register flop directly
    always_comb begin
        first_half_count_en         = drive_r.count_a;
        second_half_count_en        = drive_r.count_b;
        calendar_tick_en            = drive_r.calendar_tick_en;
        first_half_pulse_invert_eff = drive_r.pulse_invert_a;
        first_half_trigger_en       = drive_r.trigger_en_a;
        first_half_capture_rise     = drive_r.rise_a;
        first_half_capture_fall     = drive_r.fall_a;
        ctrl_fields                 = ctrl_r;
    end
endmodule : dtc_control
`default_nettype wire

// ---- sim/dtc_props.sv ----
// assertion checker for the dual timer control fields block
`timescale 1ns/1ps
`default_nettype none
module dtc_props #(
    parameter int ADDR_W = 12
) (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [ADDR_W-1:0]  paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [3:0]         pstrb,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic               cpu_halted,
    input wire logic               first_half_output_mode,
    input wire logic               first_half_count_en,
    input wire logic               second_half_count_en,
    input wire logic               calendar_tick_en,
    input wire logic               first_half_pulse_invert_eff,
    input wire logic               first_half_trigger_en,
    input wire logic               first_half_capture_rise,
    input wire logic               first_half_capture_fall,
    input wire dtc_pkg::dtc_ctrl_t ctrl_fields
);
    logic [10:0] prev_r;
    logic [10:0] prev_nxt;
    logic [1:0]  cnt_r;
    logic [1:0]  cnt_nxt;
    logic        h;
    logic        m;
    dtc_pkg::dtc_ctrl_t c;
    assign h = cpu_halted;
    assign m = first_half_output_mode;
    assign c = ctrl_fields;
    logic        quiet;
    logic [8:0]  merged;
    // inputs unchanged over the last four cycles and the current one
    assign quiet = (cnt_r == 2'h3) && (prev_nxt == prev_r);
    // stored fields after a write: strobed lanes from the bus, the rest kept
    assign merged = {pstrb[1] ? pwdata[9:8] : c[8:7], pstrb[0] ? pwdata[6:0] : c[6:0]};
    // counts quiet cycles so the synchroniser delay has passed
    always_comb begin
        prev_nxt = {h, m, c};
        cnt_nxt = (prev_nxt != prev_r) ? 2'h0 : cnt_r + {1'b0, cnt_r != 2'h3};
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r <= '0;
            cnt_r <= '0;
        end else begin
            prev_r <= prev_nxt;
            cnt_r <= cnt_nxt;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_first_count: assert property (quiet |->
        first_half_count_en == (c.first_half_run && !(c.first_half_debug_freeze && h)))
        else $error("first half count enable wrong");
    a_second_count: assert property (quiet |->
        second_half_count_en == (c.second_half_run && !(c.second_half_debug_freeze && h)))
        else $error("second half count enable wrong");
    a_calendar_en: assert property (quiet |->
        calendar_tick_en == c.calendar_count_on) else $error("calendar enable wrong");
    a_invert_gated: assert property (quiet |->
        first_half_pulse_invert_eff == (c.first_half_pulse_invert && m))
        else $error("pulse invert wrong");
    a_trigger_gated: assert property (quiet |->
        first_half_trigger_en == (c.first_half_trigger_out_on && m))
        else $error("trigger enable wrong");
    a_edge_decode: assert property (quiet |->
        {first_half_capture_rise, first_half_capture_fall} ==
        {c.first_half_edge_select inside {2'h0, 2'h3}, c.first_half_edge_select[0]})
        else $error("capture edge decode wrong");
    a_write_lands: assert property (psel && penable && pready && pwrite &&
        paddr == ADDR_W'(dtc_pkg::TIMER_CONTROL_OFFSET) |=> ctrl_fields == $past(merged))
        else $error("control write lost");
    a_hold_idle: assert property (!(psel && penable && pready && pwrite) |=>
        $stable(ctrl_fields)) else $error("control fields changed without a write");
    a_reserved_zero: assert property (pready && !pslverr |->
        prdata[31:10] == 22'h0 && !prdata[7]) else $error("reserved bits not zero");
endmodule : dtc_props
bind dtc_control dtc_props #(.ADDR_W(ADDR_W)) u_dtc_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_halted(cpu_halted),
    .first_half_output_mode(first_half_output_mode),
    .first_half_count_en(first_half_count_en), .second_half_count_en(second_half_count_en),
    .calendar_tick_en(calendar_tick_en),
    .first_half_pulse_invert_eff(first_half_pulse_invert_eff),
    .first_half_trigger_en(first_half_trigger_en),
    .first_half_capture_rise(first_half_capture_rise),
    .first_half_capture_fall(first_half_capture_fall), .ctrl_fields(ctrl_fields));
`default_nettype wire

// ---- sim/dtc_control_tb.sv ----
// self-checking bench for the dual timer control fields block
`timescale 1ns/1ps
`default_nettype none
module dtc_control_tb;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        halt = 0, mode = 0, pready, pslverr, er;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0]  pstrb = 4'hf;
    wire  [6:0]  outs;
    dtc_pkg::dtc_ctrl_t fields;
    int          n_errors = 0, total_checks = 0, mdl = 0;
    // free-running bus clock
    always #50 pclk = ~pclk;
    dtc_control #(.ADDR_W(12)) u_dtc_control (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_halted(halt), .first_half_output_mode(mode),
        .first_half_count_en(outs[6]), .second_half_count_en(outs[5]),
        .calendar_tick_en(outs[4]), .first_half_pulse_invert_eff(outs[3]),
        .first_half_trigger_en(outs[2]), .first_half_capture_rise(outs[1]),
        .first_half_capture_fall(outs[0]), .ctrl_fields(fields));
    task automatic print_verdict();
        if (n_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    // one apb transfer, held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        int n;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            n_errors++;
            print_verdict();
        end
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask : xfer
    // read back the register and the derived enables against the model
    task automatic check_all();
        logic [31:0] e;
        xfer(1'b0, 12'h00c, 32'h0, 4'h0);
        chk("ctrl read", mdl, rd);
        chk("ctrl err", 32'h0, {31'h0, er});
        repeat (6) @(posedge pclk);
        e = {25'h0, mdl[0] & ~(mdl[1] & halt), mdl[8] & ~(mdl[9] & halt), mdl[4],
             mdl[6] & mode, mdl[5] & mode, ~(mdl[3] ^ mdl[2]), mdl[2]};
        chk("enables", e, {25'h0, outs});
        chk("fields", {mdl[9:8], mdl[6:0]}, {23'h0, fields});
    endtask : check_all
    // reset, random writes with strobes, unmapped accesses, mid-run reset
    initial begin
        logic [31:0] d;
        logic [3:0]  s;
        d = $urandom(32'h72e6e917);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        check_all();
        for (int i = 0; i < 24; i++) begin
            d = $urandom;
            s = (i % 3 == 2) ? 4'($urandom) : 4'hf;
            if (i < 4) d[3:2] = 2'(i);
            d[7] = rd[7];
            halt <= 1'($urandom);
            mode <= 1'($urandom);
            xfer(1'b1, 12'h00c, d, s);
            for (int b = 0; b < 4; b++) if (s[b]) mdl[8*b+:8] = d[8*b+:8];
            mdl = mdl & 32'h37f;
            check_all();
        end
        xfer(1'b1, 12'h010, 32'h3ff, 4'hf);
        chk("unmapped err", 32'h1, {31'h0, er});
        xfer(1'b0, 12'h008, 32'h0, 4'h0);
        chk("unmapped data", 32'h0, rd);
        chk("unmapped rd err", 32'h1, {31'h0, er});
        check_all();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        mdl = 0;
        check_all();
        print_verdict();
    end
endmodule : dtc_control_tb
`default_nettype wire
